// file: core/dsp_slice_mac_alu.sv
// multiplier / accumulator / ALU slice with APB configuration and interrupt
// assumes fabric inputs synchronous to pclk; cascade_in fed from a neighbour's cascade_out
`timescale 1ns/100ps

// How it works
// - product stage runs as one 18x36, two 18x18 or four 9x9 multipliers
// - cascade input shifted right 18 lets two slices build a 36x36 product
// - accumulate mode adds each product into a 54-bit accumulator
// - dual sum mode adds both 18x18 products per cycle, 52-bit accumulation
// - ALU adds or subtracts three operands in one operation
// - ALU logic functions AND, OR, NAND, NOR, XOR, XNOR on two operands
// - opcode is a run-time input applied as presented, no reconfiguration
// - eight flags, each set to detect a chosen pattern or result condition
// - cascade input, cascade output and cascade operand select chain slices
// - cascade input registered to match the slice's pipeline stages
// - cascade output may feed a slice in another row for long chains
// - multiplier bypass makes the slice a plain adder up to 54 bits
// - rounding adds a constant then clears bits below the rounding point
// - rounding toward zero, toward infinity, dynamic, random and convergent
// - optional saturation clamps to range instead of wrapping
module dsp_slice_mac_alu
  import dsp_slice_pkg::*;
(
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              ce,
  input  wire operand_type       operands,
  input  wire logic [3:0]        alu_opcode,
  input  wire logic [ACC_W-1:0]  round_dynamic,
  input  wire logic [ACC_W-1:0]  cascade_in,
  output logic [ACC_W-1:0]       cascade_out,
  output logic [ACC_W-1:0]       result,
  output logic [PROD_W-1:0]      product,
  output logic [FLAG_N-1:0]      flags,
  output logic                   irq
);

  logic [31:0]        ctrl_reg, flagcfg_reg, pattern_reg, mask_reg;
  logic [FLAG_N-1:0]  status_reg, enable_reg;
  logic [31:0]        prdata_reg;
  logic               pready_reg, pslverr_reg, irq_reg;
  operand_type        op1_reg;
  logic [3:0]         opc1_reg, opc2_reg;
  logic [ACC_W-1:0]   casc1_reg, casc2_reg, rdyn1_reg, rdyn2_reg, c2_reg;
  logic signed [SUM_W-1:0] x2_reg;
  logic [PROD_W-1:0]  prod_reg;
  logic [ACC_W-1:0]   acc_reg;
  logic [FLAG_N-1:0]  flags_reg;
  logic               ovf_reg, sat_reg;
  logic [LFSR_W-1:0]  lfsr_reg;

  // control decode
  wire mult_mode_type mode_now  = mult_mode_type'(ctrl_reg[CTRL_MODE_LSB +: 2]);
  wire                acc_en    = ctrl_reg[CTRL_ACC_BIT];
  wire                dual_multiply_sum_mode = ctrl_reg[CTRL_DUAL_BIT];
  wire                sat_en    = ctrl_reg[CTRL_SAT_BIT];
  wire                casc_use  = ctrl_reg[CTRL_CASC_BIT];
  wire                casc_shift = ctrl_reg[CTRL_SHIFT_BIT];
  wire round_type     rmeth     = round_type'(ctrl_reg[CTRL_RMETH_LSB +: 3]);
  wire [5:0]          rpoint    = ctrl_reg[CTRL_RPT_LSB +: 6];
  wire                round_en  = ctrl_reg[CTRL_RND_BIT];

  // ---------------- multipliers ----------------
  logic signed [ACC_W-1:0]     p_single;
  logic signed [2*LANE18-1:0]  p18 [2];
  logic signed [2*LANE9-1:0]   p9 [4];
  logic [PROD_W-1:0]           product_next;
  logic signed [SUM_W-1:0]     x_next;

  assign p_single = $signed(op1_reg.a[LANE18-1:0]) * $signed(op1_reg.b);

  for (genvar i = 0; i < 2; i++)
  begin : g_lane18
    assign p18[i] = $signed(op1_reg.a[LANE18*i +: LANE18]) * $signed(op1_reg.b[LANE18*i +: LANE18]);
  end

  for (genvar i = 0; i < 4; i++)
  begin : g_lane9
    assign p9[i] = $signed(op1_reg.a[LANE9*i +: LANE9]) * $signed(op1_reg.b[LANE9*i +: LANE9]);
  end

  always_comb
  begin
    unique case (mode_now)
      MODE_18X36:
      begin
        product_next = PROD_W'(p_single);
        x_next       = SUM_W'(p_single);
      end
      MODE_TWO_18X18:
      begin
        product_next = {p18[1], p18[0]};
        // in dual sum mode both products reach the adder in the same cycle, otherwise only p18[0]
        x_next = dual_multiply_sum_mode ? SUM_W'(p18[0]) + SUM_W'(p18[1])
                                        : SUM_W'(p18[0]);
      end
      MODE_FOUR_9X9:
      begin
        product_next = {p9[3], p9[2], p9[1], p9[0]};
        x_next = SUM_W'(p9[0]) + SUM_W'(p9[1]) + SUM_W'(p9[2]) + SUM_W'(p9[3]);
      end
      MODE_BYPASS:
      begin
        product_next = {op1_reg.a, op1_reg.b};
        x_next = SUM_W'($signed({op1_reg.a[LANE18-1:0], op1_reg.b}));
      end
    endcase
  end

  // ---------------- ALU ----------------
  wire alu_op_type opc = alu_op_type'(opc2_reg);
  wire is_arith = (opc == OP_ADD_ADD) || (opc == OP_ADD_SUB) ||
                  (opc == OP_SUB_ADD) || (opc == OP_SUB_SUB);
  wire signed [SUM_W-1:0] y_val = SUM_W'($signed(c2_reg));
  wire signed [SUM_W-1:0] z_raw = SUM_W'($signed(casc2_reg));
  // shifted cascade aligns the low slice's partial product for a 36x36 pair
  wire signed [SUM_W-1:0] z_val = !casc_use ? '0 :
                                  (casc_shift ? (z_raw >>> CASC_SHIFT) : z_raw);
  wire signed [SUM_W-1:0] fb_val = acc_en ? SUM_W'($signed(acc_reg)) : '0;
  wire y_neg = (opc == OP_SUB_ADD) || (opc == OP_SUB_SUB);
  wire z_neg = (opc == OP_ADD_SUB) || (opc == OP_SUB_SUB);
  wire signed [SUM_W-1:0] y_term = y_neg ? -y_val : y_val;
  wire signed [SUM_W-1:0] z_term = z_neg ? -z_val : z_val;
  wire signed [SUM_W-1:0] arith_sum = x2_reg + y_term + z_term + fb_val;

  // rounding
  wire round_active = round_en && (rpoint != 6'h00);
  wire signed [SUM_W-1:0] low_ones = (SUM_W'(1) << rpoint) - SUM_W'(1);
  wire signed [SUM_W-1:0] half_val = round_active ? (SUM_W'(1) << (rpoint - 6'h01)) : '0;
  wire sum_neg = arith_sum[SUM_W-1];
  logic signed [SUM_W-1:0] rconst;

  always_comb
  begin
    unique case (rmeth)
      ROUND_TOWARD_ZERO:     rconst = sum_neg ? low_ones : '0;
      ROUND_TOWARD_INFINITY: rconst = sum_neg ? half_val - SUM_W'(1) : half_val;
      ROUND_DYNAMIC:         rconst = SUM_W'(rdyn2_reg) & low_ones;
      ROUND_RANDOM:          rconst = SUM_W'(lfsr_reg) & low_ones;
      ROUND_CONVERGENT:      rconst = half_val - SUM_W'(1) + SUM_W'(arith_sum[rpoint]);
      default:               rconst = '0;
    endcase
  end

  wire signed [SUM_W-1:0] rounded = round_active ? ((arith_sum + rconst) & ~low_ones)
                                                 : arith_sum;

  // saturation against 54 or, in dual sum mode, 52 bits
  wire signed [SUM_W-1:0] lim_max = dual_multiply_sum_mode ?
                                    (SUM_W'(1) << (DUAL_W - 1)) - SUM_W'(1) :
                                    (SUM_W'(1) << (ACC_W - 1)) - SUM_W'(1);
  wire signed [SUM_W-1:0] lim_min = -lim_max - SUM_W'(1);
  wire fits = (rounded <= lim_max) && (rounded >= lim_min);
  wire signed [SUM_W-1:0] wrapped = dual_multiply_sum_mode ? SUM_W'($signed(rounded[DUAL_W-1:0]))
                                                           : SUM_W'($signed(rounded[ACC_W-1:0]));
  wire signed [SUM_W-1:0] arith_fin = fits ? rounded :
                                      (sat_en ? (sum_neg ? lim_min : lim_max) : wrapped);

  logic [ACC_W-1:0] logic_res;

  always_comb
  begin
    unique case (opc)
      OP_AND:  logic_res = x2_reg[ACC_W-1:0] & c2_reg;
      OP_OR:   logic_res = x2_reg[ACC_W-1:0] | c2_reg;
      OP_NAND: logic_res = ~(x2_reg[ACC_W-1:0] & c2_reg);
      OP_NOR:  logic_res = ~(x2_reg[ACC_W-1:0] | c2_reg);
      OP_XOR:  logic_res = x2_reg[ACC_W-1:0] ^ c2_reg;
      OP_XNOR: logic_res = ~(x2_reg[ACC_W-1:0] ^ c2_reg);
      default: logic_res = '0;
    endcase
  end

  wire [ACC_W-1:0] acc_next = is_arith ? arith_fin[ACC_W-1:0] : logic_res;
  wire ovf_next = is_arith && !fits;
  wire sat_next = ovf_next && sat_en;

  // ---------------- flags ----------------
  function automatic logic flag_eval(input flag_cond_type cond, input logic [ACC_W-1:0] v,
                                     input logic match, input logic ovf, input logic sat);
    logic res;
    res = 1'b0;
    unique case (cond)
      COND_MATCH:     res = match;
      COND_MATCH_INV: res = !match;
      COND_ZERO:      res = (v == '0);
      COND_ONES:      res = (v == '1);
      COND_NEG:       res = v[ACC_W-1];
      COND_OVERFLOW:  res = ovf;
      COND_SATURATED: res = sat;
      COND_POS:       res = !v[ACC_W-1] && (v != '0);
    endcase
    return res;
  endfunction

  wire pattern_match = ((acc_next[31:0] ^ pattern_reg) & mask_reg) == 32'h0000_0000;
  logic [FLAG_N-1:0] flag_next;

  for (genvar i = 0; i < FLAG_N; i++)
  begin : g_flag
    assign flag_next[i] = flag_eval(flag_cond_type'(flagcfg_reg[COND_W*i +: COND_W]),
                                    acc_next, pattern_match, ovf_next, sat_next);
  end

  // ---------------- datapath registers ----------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      op1_reg   <= '0;
      opc1_reg  <= '0;
      casc1_reg <= '0;
      rdyn1_reg <= '0;
      opc2_reg  <= '0;
      casc2_reg <= '0;
      rdyn2_reg <= '0;
      c2_reg    <= '0;
      x2_reg    <= '0;
      prod_reg  <= '0;
    end
    else if (ce)
    begin
      op1_reg   <= operands;
      opc1_reg  <= alu_opcode;
      casc1_reg <= cascade_in;
      rdyn1_reg <= round_dynamic;
      opc2_reg  <= opc1_reg;
      casc2_reg <= casc1_reg;
      rdyn2_reg <= rdyn1_reg;
      c2_reg    <= op1_reg.c;
      x2_reg    <= x_next;
      prod_reg  <= product_next;
    end
  end

  // lfsr advances with the clock enable so its sequence tracks data samples
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      acc_reg   <= '0;
      flags_reg <= '0;
      ovf_reg   <= 1'b0;
      sat_reg   <= 1'b0;
      lfsr_reg  <= LFSR_SEED;
    end
    else if (ce)
    begin
      acc_reg   <= acc_next;
      flags_reg <= flag_next;
      ovf_reg   <= ovf_next;
      sat_reg   <= sat_next;
      lfsr_reg  <= {lfsr_reg[LFSR_W-2:0],
                    lfsr_reg[31] ^ lfsr_reg[21] ^ lfsr_reg[1] ^ lfsr_reg[0]};
    end
  end

  // ---------------- APB slave, one wait state ----------------
  wire apb_access = psel && penable;
  wire apb_done   = apb_access && pready_reg;
  wire wr_done    = apb_done && pwrite;
  wire hit_ctrl   = (paddr == CTRL_OFS);
  wire hit_fcfg   = (paddr == FLAGCFG_OFS);
  wire hit_pat    = (paddr == PATTERN_OFS);
  wire hit_mask   = (paddr == MASK_OFS);
  wire hit_stat   = (paddr == STATUS_OFS);
  wire hit_clr    = (paddr == CLEAR_OFS);
  wire hit_en     = (paddr == ENABLE_OFS);
  wire hit_rlo    = (paddr == RESULT_LO_OFS);
  wire hit_rhi    = (paddr == RESULT_HI_OFS);
  wire mapped     = hit_ctrl | hit_fcfg | hit_pat | hit_mask | hit_stat |
                    hit_clr | hit_en | hit_rlo | hit_rhi;
  wire [31:0] rd_data = hit_ctrl ? {15'h0000, ctrl_reg[CTRL_W-1:0]} :
                        hit_fcfg ? flagcfg_reg :
                        hit_pat  ? pattern_reg :
                        hit_mask ? mask_reg :
                        hit_stat ? {24'h000000, status_reg} :
                        hit_en   ? {24'h000000, enable_reg} :
                        hit_rlo  ? acc_reg[31:0] :
                        hit_rhi  ? {10'h000, acc_reg[ACC_W-1:32]} : 32'h0000_0000;
  wire [FLAG_N-1:0] clr_bits = (wr_done && hit_clr) ? pwdata[FLAG_N-1:0] : '0;
  wire [FLAG_N-1:0] events   = ce ? flag_next : '0;
  // a flag event in the clearing cycle survives the clear
  wire [FLAG_N-1:0] status_next = (status_reg & ~clr_bits) | events;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= 32'h0000_0000;
    end
    else
    begin
      pready_reg  <= apb_access && !pready_reg;
      pslverr_reg <= apb_access && !pready_reg && !mapped;
      if (apb_access && !pready_reg && !pwrite)
        prdata_reg <= rd_data;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_reg    <= CTRL_RESET;
      flagcfg_reg <= FLAGCFG_RESET;
      pattern_reg <= 32'h0000_0000;
      mask_reg    <= MASK_RESET;
      enable_reg  <= '0;
    end
    else if (wr_done)
    begin
      if (hit_ctrl)
        ctrl_reg <= {15'h0000, pwdata[CTRL_W-1:0]};
      if (hit_fcfg)
        flagcfg_reg <= {8'h00, pwdata[COND_W*FLAG_N-1:0]};
      if (hit_pat)
        pattern_reg <= pwdata;
      if (hit_mask)
        mask_reg <= pwdata;
      if (hit_en)
        enable_reg <= pwdata[FLAG_N-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      status_reg <= '0;
      irq_reg    <= 1'b0;
    end
    else
    begin
      status_reg <= status_next;
      irq_reg    <= |(status_next & enable_reg);
    end
  end

  assign prdata      = prdata_reg;
  assign pready      = pready_reg;
  assign pslverr     = pslverr_reg;
  assign cascade_out = acc_reg;
  assign result      = acc_reg;
  assign product     = prod_reg;
  assign flags       = flags_reg;
  assign irq         = irq_reg;

  // ---------------- assertions ----------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence two_enables;
    ce ##1 ce;
  endsequence

  wire plain_arith = !round_active && !sat_en && !dual_multiply_sum_mode && !casc_use;

  a_single_product: assert property (
    ce && mode_now == MODE_18X36 |=> $signed(prod_reg[ACC_W-1:0]) ==
      $signed($past(op1_reg.a[LANE18-1:0])) * $signed($past(op1_reg.b)))
    else $error("18x36 product wrong");

  a_bypass_pass: assert property (
    ce && mode_now == MODE_BYPASS |=> prod_reg == $past({op1_reg.a, op1_reg.b}))
    else $error("bypass did not pass operands");

  a_accum_adds: assert property (
    ce && acc_en && opc == OP_ADD_ADD && plain_arith && fits |=>
      acc_reg == $past(acc_reg) + $past(x2_reg[ACC_W-1:0]) + $past(c2_reg))
    else $error("accumulator did not add product");

  a_ternary_sub: assert property (
    ce && !acc_en && opc == OP_SUB_SUB && plain_arith && fits |=>
      acc_reg == $past(x2_reg[ACC_W-1:0]) - $past(c2_reg))
    else $error("ternary subtract wrong");

  a_logic_xor: assert property (
    ce && opc == OP_XOR |=> acc_reg == ($past(x2_reg[ACC_W-1:0]) ^ $past(c2_reg)))
    else $error("xor result wrong");

  a_opcode_follows: assert property (
    two_enables |=> opc2_reg == $past(alu_opcode, 2))
    else $error("opcode not applied as presented");

  a_cascade_aligned: assert property (
    two_enables |=> casc2_reg == $past(cascade_in, 2))
    else $error("cascade pipeline misaligned");

  a_dual_width: assert property (
    ce && dual_multiply_sum_mode && is_arith |=>
      acc_reg[ACC_W-1:DUAL_W-1] == '0 || acc_reg[ACC_W-1:DUAL_W-1] == '1)
    else $error("dual sum exceeds 52 bits");

  a_round_clears: assert property (
    ce && round_active && is_arith && fits |=> (acc_reg & $past(low_ones[ACC_W-1:0])) == '0)
    else $error("rounding left low bits");

  a_sat_clamps: assert property (
    ce && sat_next |=> acc_reg == $past(lim_max[ACC_W-1:0]) ||
                       acc_reg == $past(lim_min[ACC_W-1:0]))
    else $error("saturation did not clamp");

  a_flag_zero: assert property (
    ce && flagcfg_reg[COND_W-1:0] == COND_ZERO |=> flags_reg[0] == (acc_reg == '0))
    else $error("zero flag wrong");

  a_hold_no_enable: assert property (
    !ce |=> $stable(acc_reg) && $stable(prod_reg))
    else $error("register moved without enable");

  a_random_moves: assert property (
    ce |=> lfsr_reg != $past(lfsr_reg))
    else $error("random source stuck");

endmodule

// file: core/dsp_slice_pkg.sv
// constants, enumerations and carrier types of the arithmetic slice
// assumes one 40 MHz clock (pclk) and APB register access
package dsp_slice_pkg;

  localparam int A_W      = 36;
  localparam int B_W      = 36;
  localparam int C_W      = 54;
  localparam int ACC_W    = 54;
  localparam int DUAL_W   = 52;
  localparam int SUM_W    = 56;
  localparam int PROD_W   = 72;
  localparam int LANE18   = 18;
  localparam int LANE9    = 9;
  localparam int FLAG_N   = 8;
  localparam int COND_W   = 3;
  localparam int LFSR_W   = 32;
  localparam int CASC_SHIFT = 18;
  localparam int ADDR_W   = 8;

  // register byte offsets
  localparam logic [7:0] CTRL_OFS      = 8'h00;
  localparam logic [7:0] FLAGCFG_OFS   = 8'h04;
  localparam logic [7:0] PATTERN_OFS   = 8'h08;
  localparam logic [7:0] MASK_OFS      = 8'h0C;
  localparam logic [7:0] STATUS_OFS    = 8'h10;
  localparam logic [7:0] CLEAR_OFS     = 8'h14;
  localparam logic [7:0] ENABLE_OFS    = 8'h18;
  localparam logic [7:0] RESULT_LO_OFS = 8'h1C;
  localparam logic [7:0] RESULT_HI_OFS = 8'h20;

  // control register fields
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_ACC_BIT  = 2;
  localparam int CTRL_DUAL_BIT = 3;
  localparam int CTRL_SAT_BIT  = 4;
  localparam int CTRL_CASC_BIT = 5;
  localparam int CTRL_SHIFT_BIT = 6;
  localparam int CTRL_RMETH_LSB = 7;
  localparam int CTRL_RPT_LSB  = 10;
  localparam int CTRL_RND_BIT  = 16;
  localparam int CTRL_W        = 17;

  localparam logic [31:0] CTRL_RESET    = 32'h0000_0000;
  localparam logic [31:0] FLAGCFG_RESET = 32'h0000_0000;
  localparam logic [31:0] MASK_RESET    = 32'hFFFF_FFFF;
  localparam logic [LFSR_W-1:0] LFSR_SEED = 32'h0000_0001;

  typedef enum logic [1:0] {MODE_18X36, MODE_TWO_18X18, MODE_FOUR_9X9, MODE_BYPASS} mult_mode_type;

  typedef enum logic [3:0] {
    OP_ADD_ADD, OP_ADD_SUB, OP_SUB_ADD, OP_SUB_SUB,
    OP_AND, OP_OR, OP_NAND, OP_NOR, OP_XOR, OP_XNOR
  } alu_op_type;

  typedef enum logic [2:0] {
    ROUND_TOWARD_ZERO, ROUND_TOWARD_INFINITY, ROUND_DYNAMIC, ROUND_RANDOM, ROUND_CONVERGENT
  } round_type;

  typedef enum logic [2:0] {
    COND_MATCH, COND_MATCH_INV, COND_ZERO, COND_ONES,
    COND_NEG, COND_OVERFLOW, COND_SATURATED, COND_POS
  } flag_cond_type;

  typedef struct packed {
    logic [A_W-1:0] a;
    logic [B_W-1:0] b;
    logic [C_W-1:0] c;
  } operand_type;

endpackage

// file: dv/fabric_source.sv
// fabric-side partner: registers operands, opcode and dynamic rounding constant
// assumes the bench updates its request inputs by non-blocking assignment after rising pclk
`timescale 1ns/100ps
module fabric_source
  import dsp_slice_pkg::*;
(
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             stall,
  input  wire operand_type      next_ops,
  input  wire logic [3:0]       next_op,
  input  wire logic [ACC_W-1:0] next_round,
  output logic                  ce,
  output operand_type           operands,
  output logic [3:0]            alu_opcode,
  output logic [ACC_W-1:0]      round_dynamic
);
  // slow fabric is modelled by dropping ce, which freezes the slice's datapath registers; APB access still works
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ce            <= 1'b0;
      operands      <= '0;
      alu_opcode    <= 4'h0;
      round_dynamic <= '0;
    end
    else
    begin
      ce            <= !stall;
      operands      <= next_ops;
      alu_opcode    <= next_op;
      round_dynamic <= next_round;
    end
  end
endmodule

// file: dv/testbench.sv
// self-checking bench for the arithmetic slice: table of datapath cases, then hand tests
// assumes fabric_source drives the operand side; APB master lives in tasks here
`timescale 1ns/100ps
`define CHK(g, e) check_val(72'(g), 72'(e))
module testbench;
  import dsp_slice_pkg::*;
  typedef struct {
    logic [31:0] ctrl;
    logic [3:0]  op;
    logic [35:0] a;
    logic [35:0] b;
    logic [53:0] c;
    logic [53:0] exp;
  } row_type;
  logic              pclk, presetn, psel, penable, pwrite, pready, pslverr, ce, irq, stall, err;
  logic [ADDR_W-1:0] paddr;
  logic [31:0]       pwdata, prdata, rd;
  operand_type       operands, next_ops;
  logic [3:0]        alu_opcode, next_op;
  logic [ACC_W-1:0]  round_dynamic, next_round, cascade_in, cascade_out, result, r0;
  logic [PROD_W-1:0] product;
  logic [FLAG_N-1:0] flags;
  int                miscompares, n_tests, cycles;
  row_type           rows [21] = '{
    '{32'h0, 4'h0, 36'h3, 36'h5, 54'h7, 54'h16},
    '{32'h1, 4'h1, 36'h4, 36'h6, 54'h1, 54'h19},
    '{32'h2, 4'h2, 36'h2, 36'h3, 54'hA, 54'h3FFFFFFFFFFFFC},
    '{32'h3, 4'h0, 36'h1, 36'h2, 54'h3, 54'h1000000005},
    '{32'h3, 4'h4, 36'h0, 36'hF0, 54'hCC, 54'hC0},
    '{32'h3, 4'h5, 36'h0, 36'hF0, 54'hCC, 54'hFC},
    '{32'h3, 4'h6, 36'h0, 36'hF0, 54'hCC, 54'h3FFFFFFFFFFF3F},
    '{32'h3, 4'h7, 36'h0, 36'hF0, 54'hCC, 54'h3FFFFFFFFFFF03},
    '{32'h3, 4'h8, 36'h0, 36'hF0, 54'hCC, 54'h3C},
    '{32'h3, 4'h9, 36'h0, 36'hF0, 54'hCC, 54'h3FFFFFFFFFFFC3},
    '{32'h0, 4'h3, 36'hA, 36'hA, 54'h1E, 54'h46},
    '{32'h3, 4'hC, 36'h1, 36'h2, 54'h3, 54'h0},
    '{32'h9, 4'h0, 36'h80003, 36'h100005, 54'h0, 54'h17},
    '{32'h13, 4'h0, 36'h1FFFF, 36'hFFFFFFFFF, 54'h1, 54'h1FFFFFFFFFFFFF},
    '{32'h3, 4'h0, 36'h1FFFF, 36'hFFFFFFFFF, 54'h1, 54'h20000000000000},
    '{32'h11003, 4'h0, 36'h0, 36'h13, 54'h0, 54'h10},
    '{32'h11083, 4'h0, 36'h0, 36'h18, 54'h0, 54'h20},
    '{32'h11083, 4'h0, 36'h0, 36'h17, 54'h0, 54'h10},
    '{32'h11203, 4'h0, 36'h0, 36'h18, 54'h0, 54'h20},
    '{32'h11203, 4'h0, 36'h0, 36'h28, 54'h0, 54'h20},
    '{32'h11103, 4'h0, 36'h0, 36'h1F, 54'h0, 54'h10}};

  dsp_slice_mac_alu i_dsp_slice_mac_alu (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ce(ce), .operands(operands),
    .alu_opcode(alu_opcode), .round_dynamic(round_dynamic), .cascade_in(cascade_in),
    .cascade_out(cascade_out), .result(result), .product(product), .flags(flags), .irq(irq));
  fabric_source i_fabric_source (.pclk(pclk), .presetn(presetn), .stall(stall),
    .next_ops(next_ops), .next_op(next_op), .next_round(next_round), .ce(ce),
    .operands(operands), .alu_opcode(alu_opcode), .round_dynamic(round_dynamic));

  initial
  begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // the whole run needs a few hundred cycles
  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      miscompares++;
      conclude();
    end
  end

  task automatic check_val(input logic [71:0] got, input logic [71:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      miscompares++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wd);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= addr;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    // no local limit: a missing answer is ended only by the bench timeout
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic apply(input logic [31:0] ctrl, input logic [3:0] op, input logic [35:0] a,
                       input logic [35:0] b, input logic [53:0] c);
    apb(1'b1, CTRL_OFS, ctrl);
    next_op  <= op;
    next_ops <= {a, b, c};
    repeat (8) @(posedge pclk);
  endtask

  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    stall = 1'b0;
    next_ops = '0;
    next_op = 4'h0;
    next_round = '0;
    cascade_in = '0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    foreach (rows[i])
    begin
      apply(rows[i].ctrl, rows[i].op, rows[i].a, rows[i].b, rows[i].c);
      `CHK(result, rows[i].exp);
      `CHK(cascade_out, rows[i].exp);
    end
    // product stage in each multiplier split, negative lanes sign-extended; then dynamic and random rounding
    apply(32'h0, 4'h0, 36'h3FFFF, 36'h2, 54'h0);
    `CHK(product, 72'hFFFFFFFFFFFFFFFFFE);
    apply(32'h1, 4'h0, 36'h80003, 36'h100005, 54'h0);
    `CHK(product, 72'h00000000800000000F);
    apply(32'h2, 4'h0, 36'h1FF, 36'h3, 54'h0);
    `CHK(product, 72'h00000000000003FFFD);
    next_round <= 54'h1;
    apply(32'h11103, 4'h0, 36'h0, 36'h1F, 54'h0);
    `CHK(result, 54'h20);
    apply(32'h11183, 4'h0, 36'h0, 36'h18, 54'h0);
    `CHK(result[3:0], 4'h0);
    // second reset in mid-run
    presetn <= 1'b0;
    @(posedge pclk);
    `CHK(result, 54'h0);
    presetn <= 1'b1;
    apb(1'b0, MASK_OFS, 32'h0);
    `CHK(rd, 32'hFFFFFFFF);
    apb(1'b0, 8'h40, 32'h0);
    `CHK({err, rd}, 33'h100000000);
    // accumulate, then freeze with ce low
    apply(32'h4, 4'h0, 36'h1, 36'h1, 54'h0);
    stall <= 1'b1;
    repeat (3) @(posedge pclk);
    r0 = result;
    repeat (3) @(posedge pclk);
    `CHK(result, r0);
    stall <= 1'b0;
    @(posedge pclk);
    stall <= 1'b1;
    repeat (4) @(posedge pclk);
    `CHK(result, r0 + 54'h1);
    stall <= 1'b0;
    cascade_in <= 54'h5;
    apply(32'h23, 4'h0, 36'h0, 36'h0, 54'h0);
    `CHK(result, 54'h5);
    cascade_in <= 54'h140000;
    apply(32'h63, 4'h0, 36'h0, 36'h0, 54'h0);
    `CHK(result, 54'h5);
    cascade_in <= '0;
    // flag 0 detects zero, the others match pattern 0
    apb(1'b1, FLAGCFG_OFS, 32'h2);
    apb(1'b1, ENABLE_OFS, 32'h1);
    apply(32'h3, 4'h0, 36'h0, 36'h0, 54'h0);
    `CHK(flags, 8'hFF);
    `CHK(irq, 1'b1);
    apb(1'b0, STATUS_OFS, 32'h0);
    `CHK(rd[0], 1'b1);
    apb(1'b1, ENABLE_OFS, 32'h0);
    repeat (2) @(posedge pclk);
    `CHK(irq, 1'b0);
    apply(32'h3, 4'h0, 36'h0, 36'h1, 54'h0);
    `CHK(flags, 8'h00);
    apb(1'b1, CLEAR_OFS, 32'hFF);
    apb(1'b1, ENABLE_OFS, 32'h1);
    repeat (2) @(posedge pclk);
    `CHK(irq, 1'b0);
    apb(1'b0, STATUS_OFS, 32'h0);
    `CHK(rd[7:0], 8'h00);
    conclude();
  end
endmodule
